// ---- logic/rfcal_defines.svh ----
`ifndef RFCAL_DEFINES_SVH
`define RFCAL_DEFINES_SVH

// ----------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------
`define RFCAL_LOCK_CTRL_IDX      8'h0B
`define RFCAL_IRQ_GRP1_IDX       8'h0D
`define RFCAL_LOOP_CTRL_IDX      8'h15
`define RFCAL_TUNE_STAT_IDX      8'h40
`define RFCAL_LOW_INT_IDX        8'h4D
`define RFCAL_LOW_FH_IDX         8'h4E
`define RFCAL_LOW_FM_IDX         8'h4F
`define RFCAL_LOW_FL_IDX         8'h50
`define RFCAL_UP_RANGE_IDX       8'h51
`define RFCAL_CAP_LOW_IDX        8'h52
`define RFCAL_CAP_HIGH_IDX       8'h53
`define RFCAL_CHFIL_IDX          8'h54
`define RFCAL_MAG_H_IDX          8'h5A
`define RFCAL_MAG_L_IDX          8'h5B
`define RFCAL_PH_H_IDX           8'h5C
`define RFCAL_PH_L_IDX           8'h5D
`define RFCAL_WAIT_IDX           8'h5E
`define RFCAL_TARGET_IDX         8'h5F
`define RFCAL_DECIMATION_GAIN_IDX       8'h60
`define RFCAL_APPLIED_CAP_IDX    8'h6E
`define RFCAL_CAL_CTRL_IDX       8'h70
`define RFCAL_BYTE_ADDR(i)       {i, 2'b00}

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RFCAL_BIT_GO             4
`define RFCAL_BIT_UPPER_LOCAL    5
`define RFCAL_BIT_PASS           6
`define RFCAL_BIT_FINISHED       7
`define RFCAL_BIT_BELOW          0
`define RFCAL_BIT_ABOVE          1
`define RFCAL_BIT_RANGE_EN       2
`define RFCAL_BIT_STOP_EN        7
`define RFCAL_BIT_LOCK_IRQ       2
`define RFCAL_BIT_CAP_GO         0
`define RFCAL_BIT_CAP_BUSY       1

// ----------------------------------------
// Timing and reset values
// ----------------------------------------
`define RFCAL_CLK_HZ             50000000
`define RFCAL_IQ_TIME_US         100
`define RFCAL_IQ_CYCLES          ((`RFCAL_IQ_TIME_US * (`RFCAL_CLK_HZ / 1000000)))
`define RFCAL_CAP_TIME_US        50
`define RFCAL_CAP_CYCLES         ((`RFCAL_CAP_TIME_US * (`RFCAL_CLK_HZ / 1000000)))
`define RFCAL_RESET_BYTE         8'h00
`define RFCAL_RESP_OKAY          2'b00
`define RFCAL_RESP_SLVERR        2'b10

`endif

// ---- logic/rfcal_pkg.sv ----
`default_nettype none
package rfcal_pkg;

	typedef enum logic [1:0] {
		RFCAL_IDLE   = 2'b00,
		RFCAL_ADJUST = 2'b01,
		RFCAL_CAP    = 2'b10
	} rfcal_state_type;

	// Radio-side results from the analogue engine
	typedef struct packed {
		logic [15:0] magnitude;
		logic [15:0] phase;
		logic        strength_ok;
		logic [7:0]  cap_low;
		logic [7:0]  cap_high;
		logic [7:0]  freq_pos;
		logic        tune_below;
		logic        tune_above;
		logic        lock_lost;
	} rfcal_radio_in_type;

	// Radio operating status
	typedef struct packed {
		logic tx_mode;
		logic power_amp_enable;
		logic rx_enable;
	} rfcal_mode_type;

endpackage
`default_nettype wire

// ---- logic/rfcal_monitor.sv ----
// Functional notes
// - Writing go bit 4 and upper-local bit 5 in receive starts balancing.
// - Finished flag bit 7 of magnitude high goes 1 when balancing ends.
// - Magnitude and phase results held in their high/low register pairs.
// - Pass bit 6 is 0 when strength exceeded threshold; host retries.
// - Calibration stores low-limit value at 0x52, high-limit at 0x53.
// - Working capacitance interpolated from two limits, shown at 0x6E.
// - Host may rewrite limits and compensation values instead of calibrating.
// - Tuning status bits: 0 below lower limit, 1 above upper limit.
// - Bit 2 of tuning status enables range detection and its interrupt.
// - Out-of-range tuning raises lock-loss interrupt, group one bit 2.
// - Range judged at rising amp enable in transmit, rising receive enable.
// - Lock loss watched whole time amp enable is high in transmit, receive enable in receive.
// - Stop enable 1 and unlock cause in transmit: interrupt and stop transmit.
// - Stop enable 0: interrupt raised, transmission continues.
// - In receive: interrupt raised, reception continues always.
// - Lock-loss interrupt stays set until host clears it.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rfcal_defines.svh"

module rfcal_monitor #(
	parameter int IQ_CYCLES  = `RFCAL_IQ_CYCLES,
	parameter int CAP_CYCLES = `RFCAL_CAP_CYCLES
) (
	// Clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// AXI4-Lite write
	input  wire logic [8:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output var  logic                        s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output var  logic                        s_axi_wready,
	output var  logic [1:0]                  s_axi_bresp,
	output var  logic                        s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [8:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output var  logic                        s_axi_arready,
	output var  logic [31:0]                 s_axi_rdata,
	output var  logic [1:0]                  s_axi_rresp,
	output var  logic                        s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Radio side
	input  wire rfcal_pkg::rfcal_radio_in_type radio_in,
	input  wire rfcal_pkg::rfcal_mode_type     mode_in,
	output var  logic                        tx_force_stop,
	output var  logic                        balance_run,
	output var  logic                        upper_local_sel,
	output var  logic                        cap_cal_run,
	output var  logic [7:0]                  applied_cap_value,
	output var  logic                        lock_loss_irq
);
	import rfcal_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0]      lock_ctrl_r, loop_ctrl_r, chfil_r, wait_r, target_r, decimation_gain_r;
	logic [7:0]      low_int_r, low_fh_r, low_fm_r, low_fl_r, up_range_r;
	logic [7:0]      cap_low_r, cap_high_r;
	logic [15:0]     mag_r, phase_r;
	logic            finished_r, pass_r, upper_local_r, range_en_r;
	logic            below_r, above_r, irq_r, stop_r;
	rfcal_state_type state_r;
	logic [31:0]     cnt_r;
	logic            pa_d_r, rx_d_r;
	logic [7:0]      cap_app_r;

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	logic [8:0]  aw_r;
	logic        aw_have_r, w_have_r;
	logic [31:0] wd_r;
	logic [3:0]  ws_r;
	logic [31:0] rdata_nxt;
	logic        rd_hit;

	wire aw_take   = s_axi_awvalid && s_axi_awready;
	wire w_take    = s_axi_wvalid && s_axi_wready;
	wire wr_fire   = aw_have_r && w_have_r && !s_axi_bvalid;
	wire [6:0] widx = aw_r[8:2];
	wire [7:0] wb   = wd_r[7:0];
	wire wr_lane   = wr_fire && ws_r[0];
	wire rd_take   = s_axi_arvalid && s_axi_arready;

	function automatic logic hit(input logic [6:0] idx, input logic [7:0] reg_idx);
		hit = (idx == reg_idx[6:0]);
	endfunction

	function automatic logic wr_known(input logic [6:0] idx);
		wr_known = hit(idx, `RFCAL_LOCK_CTRL_IDX) || hit(idx, `RFCAL_IRQ_GRP1_IDX)
			|| hit(idx, `RFCAL_LOOP_CTRL_IDX) || hit(idx, `RFCAL_TUNE_STAT_IDX)
			|| hit(idx, `RFCAL_LOW_INT_IDX) || hit(idx, `RFCAL_LOW_FH_IDX)
			|| hit(idx, `RFCAL_LOW_FM_IDX) || hit(idx, `RFCAL_LOW_FL_IDX)
			|| hit(idx, `RFCAL_UP_RANGE_IDX) || hit(idx, `RFCAL_CAP_LOW_IDX)
			|| hit(idx, `RFCAL_CAP_HIGH_IDX) || hit(idx, `RFCAL_CHFIL_IDX)
			|| hit(idx, `RFCAL_MAG_H_IDX) || hit(idx, `RFCAL_MAG_L_IDX)
			|| hit(idx, `RFCAL_PH_H_IDX) || hit(idx, `RFCAL_PH_L_IDX)
			|| hit(idx, `RFCAL_WAIT_IDX) || hit(idx, `RFCAL_TARGET_IDX)
			|| hit(idx, `RFCAL_DECIMATION_GAIN_IDX) || hit(idx, `RFCAL_APPLIED_CAP_IDX)
			|| hit(idx, `RFCAL_CAL_CTRL_IDX);
	endfunction

	// Write decode
	wire w_lock   = wr_lane && hit(widx, `RFCAL_LOCK_CTRL_IDX);
	wire w_irq    = wr_lane && hit(widx, `RFCAL_IRQ_GRP1_IDX);
	wire w_tune   = wr_lane && hit(widx, `RFCAL_TUNE_STAT_IDX);
	wire w_magh   = wr_lane && hit(widx, `RFCAL_MAG_H_IDX);
	wire w_magl   = wr_lane && hit(widx, `RFCAL_MAG_L_IDX);
	wire w_phh    = wr_lane && hit(widx, `RFCAL_PH_H_IDX);
	wire w_phl    = wr_lane && hit(widx, `RFCAL_PH_L_IDX);
	wire w_caplo  = wr_lane && hit(widx, `RFCAL_CAP_LOW_IDX);
	wire w_caphi  = wr_lane && hit(widx, `RFCAL_CAP_HIGH_IDX);
	wire w_calctl = wr_lane && hit(widx, `RFCAL_CAL_CTRL_IDX);

	// ----------------------------------------
	// Sequencer events
	// ----------------------------------------
	wire go_req      = w_magh && wb[`RFCAL_BIT_GO] && state_r == RFCAL_IDLE;
	wire cap_req     = w_calctl && wb[`RFCAL_BIT_CAP_GO] && state_r == RFCAL_IDLE;
	wire cnt_done    = (cnt_r == 32'h00000001);
	wire adjust_end  = state_r == RFCAL_ADJUST && cnt_done;
	wire cap_end     = state_r == RFCAL_CAP && cnt_done;

	// Monitoring windows and edges
	wire pa_rise     = mode_in.power_amp_enable && !pa_d_r;
	wire rx_rise     = mode_in.rx_enable && !rx_d_r;
	wire judge_now   = range_en_r && ((mode_in.tx_mode && pa_rise)
		|| (!mode_in.tx_mode && rx_rise));
	wire out_range   = radio_in.tune_below || radio_in.tune_above;
	wire range_event = judge_now && out_range;
	wire watch_win   = mode_in.tx_mode ? mode_in.power_amp_enable : mode_in.rx_enable;
	wire lock_event  = watch_win && radio_in.lock_lost;
	wire unlock_any  = range_event || lock_event;
	wire tx_unlock   = unlock_any && mode_in.tx_mode && lock_ctrl_r[`RFCAL_BIT_STOP_EN];

	// Interpolation between the two limits; pos 0 gives low, 255 near high
	wire [16:0] interp_sum = {9'h000, cap_low_r} * 17'(9'h100 - {1'b0, radio_in.freq_pos})
		+ {9'h000, cap_high_r} * 17'({1'b0, radio_in.freq_pos});
	wire [7:0] cap_interp = interp_sum[15:8];

	// ----------------------------------------
	// Bus channel registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			aw_r          <= 9'h000;
			wd_r          <= 32'h00000000;
			ws_r          <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RFCAL_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_r && !aw_take;
			s_axi_wready  <= !w_have_r && !w_take;
			if (aw_take) begin
				aw_have_r <= 1'b1;
				aw_r      <= s_axi_awaddr;
			end
			if (w_take) begin
				w_have_r <= 1'b1;
				wd_r     <= s_axi_wdata;
				ws_r     <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known(widx) ? `RFCAL_RESP_OKAY : `RFCAL_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_have_r     <= 1'b0;
				w_have_r      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read mux
	wire [6:0] ridx = s_axi_araddr[8:2];
	always_comb begin
		rd_hit    = 1'b1;
		rdata_nxt = 32'h00000000;
		case ({1'b0, ridx})
			`RFCAL_LOCK_CTRL_IDX:    rdata_nxt[7:0] = lock_ctrl_r;
			`RFCAL_IRQ_GRP1_IDX:     rdata_nxt[`RFCAL_BIT_LOCK_IRQ] = irq_r;
			`RFCAL_LOOP_CTRL_IDX:    rdata_nxt[7:0] = loop_ctrl_r;
			`RFCAL_TUNE_STAT_IDX:    rdata_nxt[2:0] = {range_en_r, above_r, below_r};
			`RFCAL_LOW_INT_IDX:      rdata_nxt[7:0] = low_int_r;
			`RFCAL_LOW_FH_IDX:       rdata_nxt[7:0] = low_fh_r;
			`RFCAL_LOW_FM_IDX:       rdata_nxt[7:0] = low_fm_r;
			`RFCAL_LOW_FL_IDX:       rdata_nxt[7:0] = low_fl_r;
			`RFCAL_UP_RANGE_IDX:     rdata_nxt[7:0] = up_range_r;
			`RFCAL_CAP_LOW_IDX:      rdata_nxt[7:0] = cap_low_r;
			`RFCAL_CAP_HIGH_IDX:     rdata_nxt[7:0] = cap_high_r;
			`RFCAL_CHFIL_IDX:        rdata_nxt[7:0] = chfil_r;
			`RFCAL_MAG_H_IDX:        rdata_nxt[7:0] = {finished_r, pass_r, upper_local_r,
				state_r == RFCAL_ADJUST, mag_r[11:8]};
			`RFCAL_MAG_L_IDX:        rdata_nxt[7:0] = mag_r[7:0];
			`RFCAL_PH_H_IDX:         rdata_nxt[7:0] = phase_r[15:8];
			`RFCAL_PH_L_IDX:         rdata_nxt[7:0] = phase_r[7:0];
			`RFCAL_WAIT_IDX:         rdata_nxt[7:0] = wait_r;
			`RFCAL_TARGET_IDX:       rdata_nxt[7:0] = target_r;
			`RFCAL_DECIMATION_GAIN_IDX:     rdata_nxt[7:0] = decimation_gain_r;
			`RFCAL_APPLIED_CAP_IDX:  rdata_nxt[7:0] = cap_app_r;
			`RFCAL_CAL_CTRL_IDX:     rdata_nxt[`RFCAL_BIT_CAP_BUSY] = (state_r == RFCAL_CAP);
			default:                 rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RFCAL_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_take;
			if (rd_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdata_nxt;
				s_axi_rresp  <= rd_hit ? `RFCAL_RESP_OKAY : `RFCAL_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Plain host registers
	// ----------------------------------------
	// Contents are only stored, except lock control bit 7 and the range enable; the host is trusted with the set-up values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_ctrl_r <= `RFCAL_RESET_BYTE;
			loop_ctrl_r <= `RFCAL_RESET_BYTE;
			chfil_r     <= `RFCAL_RESET_BYTE;
			wait_r      <= `RFCAL_RESET_BYTE;
			target_r    <= `RFCAL_RESET_BYTE;
			decimation_gain_r  <= `RFCAL_RESET_BYTE;
			low_int_r   <= `RFCAL_RESET_BYTE;
			low_fh_r    <= `RFCAL_RESET_BYTE;
			low_fm_r    <= `RFCAL_RESET_BYTE;
			low_fl_r    <= `RFCAL_RESET_BYTE;
			up_range_r  <= `RFCAL_RESET_BYTE;
			range_en_r  <= 1'b0;
		end else begin
			if (w_lock) lock_ctrl_r <= wb;
			if (wr_lane && hit(widx, `RFCAL_LOOP_CTRL_IDX)) loop_ctrl_r <= wb;
			if (wr_lane && hit(widx, `RFCAL_CHFIL_IDX)) chfil_r <= wb;
			if (wr_lane && hit(widx, `RFCAL_WAIT_IDX)) wait_r <= wb;
			if (wr_lane && hit(widx, `RFCAL_TARGET_IDX)) target_r <= wb;
			if (wr_lane && hit(widx, `RFCAL_DECIMATION_GAIN_IDX)) decimation_gain_r <= wb;
			if (wr_lane && hit(widx, `RFCAL_LOW_INT_IDX)) low_int_r <= wb;
			if (wr_lane && hit(widx, `RFCAL_LOW_FH_IDX)) low_fh_r <= wb;
			if (wr_lane && hit(widx, `RFCAL_LOW_FM_IDX)) low_fm_r <= wb;
			if (wr_lane && hit(widx, `RFCAL_LOW_FL_IDX)) low_fl_r <= wb;
			if (wr_lane && hit(widx, `RFCAL_UP_RANGE_IDX)) up_range_r <= wb;
			if (w_tune) range_en_r <= wb[`RFCAL_BIT_RANGE_EN];
		end
	end

	// ----------------------------------------
	// Calibration sequencer and results
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r       <= RFCAL_IDLE;
			cnt_r         <= 32'h00000000;
			finished_r    <= 1'b0;
			pass_r        <= 1'b0;
			upper_local_r <= 1'b0;
			mag_r         <= 16'h0000;
			phase_r       <= 16'h0000;
			cap_low_r     <= `RFCAL_RESET_BYTE;
			cap_high_r    <= `RFCAL_RESET_BYTE;
		end else begin
			case (state_r)
				RFCAL_IDLE: begin
					if (go_req) begin
						state_r       <= RFCAL_ADJUST;
						cnt_r         <= 32'(IQ_CYCLES);
						finished_r    <= 1'b0;
						pass_r        <= 1'b0;
						upper_local_r <= wb[`RFCAL_BIT_UPPER_LOCAL];
					end else if (cap_req) begin
						state_r <= RFCAL_CAP;
						cnt_r   <= 32'(CAP_CYCLES);
					end
				end
				RFCAL_ADJUST: begin
					cnt_r <= cnt_r - 32'h00000001;
					if (adjust_end) begin
						state_r    <= RFCAL_IDLE;
						finished_r <= 1'b1;
						pass_r     <= radio_in.strength_ok;
						mag_r      <= radio_in.magnitude;
						phase_r    <= radio_in.phase;
					end
				end
				RFCAL_CAP: begin
					cnt_r <= cnt_r - 32'h00000001;
					if (cap_end) state_r <= RFCAL_IDLE;
				end
				default: state_r <= RFCAL_IDLE;
			endcase
			// Host writes load results directly, skipping calibration
			if (w_magh) mag_r[11:8] <= wb[3:0];
			if (w_magl) mag_r[7:0]  <= wb;
			if (w_phh)  phase_r[15:8] <= wb;
			if (w_phl)  phase_r[7:0]  <= wb;
			if (cap_end) begin
				cap_low_r  <= radio_in.cap_low;
				cap_high_r <= radio_in.cap_high;
			end else begin
				if (w_caplo) cap_low_r  <= wb;
				if (w_caphi) cap_high_r <= wb;
			end
		end
	end

	// ----------------------------------------
	// Tuning supervision and outputs
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pa_d_r            <= 1'b0;
			rx_d_r            <= 1'b0;
			below_r           <= 1'b0;
			above_r           <= 1'b0;
			irq_r             <= 1'b0;
			stop_r            <= 1'b0;
			cap_app_r         <= `RFCAL_RESET_BYTE;
			tx_force_stop     <= 1'b0;
			balance_run       <= 1'b0;
			upper_local_sel   <= 1'b0;
			cap_cal_run       <= 1'b0;
			applied_cap_value <= `RFCAL_RESET_BYTE;
			lock_loss_irq     <= 1'b0;
		end else begin
			pa_d_r <= mode_in.power_amp_enable;
			rx_d_r <= mode_in.rx_enable;
			if (judge_now) begin
				below_r <= radio_in.tune_below;
				above_r <= radio_in.tune_above;
			end
			// Set wins over a host clear in the same cycle
			if (unlock_any) irq_r <= 1'b1;
			else if (w_irq && wb[`RFCAL_BIT_LOCK_IRQ]) irq_r <= 1'b0;
			// Stop held for the rest of the amp-on burst only
			if (tx_unlock) stop_r <= 1'b1;
			else if (!mode_in.power_amp_enable) stop_r <= 1'b0;
			cap_app_r         <= cap_interp;
			tx_force_stop     <= stop_r || tx_unlock;
			balance_run       <= (state_r == RFCAL_ADJUST);
			upper_local_sel   <= upper_local_r;
			cap_cal_run       <= (state_r == RFCAL_CAP);
			applied_cap_value <= cap_app_r;
			lock_loss_irq     <= irq_r;
		end
	end

endmodule
`default_nettype wire

// ---- bench/rfcal_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module rfcal_props (
	// Clock and reset
	input wire logic                    aclk,
	input wire logic                    aresetn,
	// Register bus
	input wire logic [8:0]              s_axi_awaddr,
	input wire logic                    s_axi_awvalid,
	input wire logic                    s_axi_awready,
	input wire logic [31:0]             s_axi_wdata,
	input wire logic                    s_axi_wvalid,
	input wire logic                    s_axi_wready,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic [31:0]             s_axi_rdata,
	input wire logic                    s_axi_rvalid,
	// Radio side
	input wire rfcal_pkg::rfcal_radio_in_type radio_in,
	input wire rfcal_pkg::rfcal_mode_type     mode_in,
	input wire logic                    tx_force_stop,
	input wire logic                    lock_loss_irq
);
	import rfcal_pkg::*;
	// Shadow copies of the enables, seen from the bus only
	logic stop_en_r;
	logic range_en_r;
	wire  wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire  clr_req = s_axi_awvalid && s_axi_awaddr == 9'h034 && s_axi_wdata[2];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stop_en_r  <= 1'h0;
			range_en_r <= 1'h0;
		end else if (wr_take && s_axi_awaddr == 9'h02C) begin
			stop_en_r  <= s_axi_wdata[7];
		end else if (wr_take && s_axi_awaddr == 9'h100) begin
			range_en_r <= s_axi_wdata[2];
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		wr_take;
	endsequence
	sequence s_unlock;
		(mode_in.tx_mode ? mode_in.power_amp_enable : mode_in.rx_enable) && radio_in.lock_lost;
	endsequence
	sequence s_tx_unlock;
		mode_in.tx_mode && mode_in.power_amp_enable && radio_in.lock_lost && stop_en_r;
	endsequence
	a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_lock_irq: assert property (s_unlock |-> ##[1:3] lock_loss_irq)
		else $error("lock loss not flagged");
	a_tune_irq: assert property ($rose(mode_in.rx_enable) && !mode_in.tx_mode && range_en_r
		&& (radio_in.tune_below || radio_in.tune_above) |-> ##[1:3] lock_loss_irq)
		else $error("tune range not flagged");
	a_stop_force: assert property (s_tx_unlock |-> ##[0:2] tx_force_stop)
		else $error("transmit not stopped");
	a_stop_holds: assert property (tx_force_stop && mode_in.power_amp_enable |=> tx_force_stop)
		else $error("stop dropped in burst");
	a_stop_cause: assert property ($rose(tx_force_stop) |-> $past(stop_en_r) &&
		$past(mode_in.tx_mode && mode_in.power_amp_enable))
		else $error("stop without cause");
	a_irq_sticky: assert property ($fell(lock_loss_irq) |->
		$past(clr_req, 1) || $past(clr_req, 2) || $past(clr_req, 3))
		else $error("irq fell without clear");
endmodule
bind rfcal_monitor rfcal_props rfcal_props_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .radio_in, .mode_in, .tx_force_stop,
	.lock_loss_irq);
`default_nettype wire

// ---- bench/rfcal_radio_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rfcal_radio_model (
	// Engine state from the block
	input wire logic                    balance_run,
	input wire logic                    cap_cal_run,
	// Values the engine settles on
	input wire rfcal_pkg::rfcal_radio_in_type radio_set,
	output var rfcal_pkg::rfcal_radio_in_type radio_in
);
	import rfcal_pkg::*;
	// Results are only valid while the engine runs; stale lines turn over
	always_comb begin
		radio_in = radio_set;
		if (!balance_run) begin
			radio_in.magnitude   = ~radio_set.magnitude;
			radio_in.phase       = ~radio_set.phase;
			radio_in.strength_ok = ~radio_set.strength_ok;
		end
		if (!cap_cal_run) begin
			radio_in.cap_low  = ~radio_set.cap_low;
			radio_in.cap_high = ~radio_set.cap_high;
		end
	end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rfcal_pkg::*;
	logic               aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic               s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic               s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic               tx_force_stop, balance_run, upper_local_sel, cap_cal_run, lock_loss_irq;
	logic [8:0]         s_axi_awaddr, s_axi_araddr;
	logic [7:0]         applied_cap_value;
	logic [31:0]        s_axi_wdata, s_axi_rdata, rd_v;
	logic [3:0]         s_axi_wstrb;
	logic [1:0]         s_axi_bresp, s_axi_rresp, rsp;
	rfcal_radio_in_type radio_in, radio_set;
	rfcal_mode_type     mode_in;
	int                 n_fail, cmp_count, seed, i, n;
	logic [7:0]         cfg_a [5] = '{8'h54, 8'h60, 8'h5E, 8'h15, 8'h5F};
	logic [7:0]         cfg_d [5] = '{8'h14, 8'h0C, 8'h00, 8'h00, 8'h5B};
	// Short counts keep the run brief
	rfcal_monitor #(.IQ_CYCLES(8), .CAP_CYCLES(8)) rfcal_monitor_i (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .radio_in, .mode_in, .tx_force_stop, .balance_run,
		.upper_local_sel, .cap_cal_run, .applied_cap_value, .lock_loss_irq);
	rfcal_radio_model rfcal_radio_model_i (.balance_run, .cap_cal_run, .radio_set, .radio_in);
	initial begin
		aclk = 1'h0;
		forever #10 aclk = ~aclk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw_t, w_t;
		aw_t = 1'h0;
		w_t = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= {a[6:0], 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw_t && w_t)) begin
			@(posedge aclk);
			if (!aw_t && s_axi_awready === 1'h1) begin
				s_axi_awvalid <= 1'h0;
				aw_t = 1'h1;
			end
			if (!w_t && s_axi_wready === 1'h1) begin
				s_axi_wvalid <= 1'h0;
				w_t = 1'h1;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= {a[6:0], 2'b00};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
		rd_v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk($sformatf("reg %h", a), {24'h000000, e}, rd_v);
	endtask
	// One unlock pulse inside the enable window, then the burst ends
	task automatic lost_pulse(input logic tx, input logic stop, input logic e);
		wr(8'h0B, {stop, 7'h00});
		mode_in <= {tx, tx, !tx};
		repeat (3) @(posedge aclk);
		radio_set.lock_lost <= 1'h1;
		@(posedge aclk);
		radio_set.lock_lost <= 1'h0;
		repeat (3) @(posedge aclk);
		chk("tx_force_stop", e, tx_force_stop);
		chk("lock_loss_irq", 1'h1, lock_loss_irq);
		mode_in <= 3'h0;
		repeat (3) @(posedge aclk);
		chk("stop_end", 1'h0, tx_force_stop);
		wr(8'h0D, 8'h04);
		$display("test unlock %0d%0d done", tx, stop);
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8000) @(posedge aclk);
		n_fail++;
		complete_run;
	end
	initial begin
		{seed, n_fail, cmp_count} = {32'd59, 64'h0};
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 51'h0;
		s_axi_wstrb = 4'hF;
		mode_in = 3'h0;
		radio_set = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		rchk(8'h40, 8'h00);
		rchk(8'h5A, 8'h00);
		rchk(8'h0D, 8'h00);
		cfg_d[4] = 8'($random(seed));
		for (i = 0; i < 5; i++) begin
			wr(cfg_a[i], cfg_d[i]);
			rchk(cfg_a[i], cfg_d[i]);
		end
		wr(8'h7F, 8'h11);
		chk("bresp", 2'h2, rsp);
		rd(8'h7F);
		chk("rresp", 2'h2, rsp);
		$display("test setup done");
		mode_in <= 3'h1;
		// Two passes always run: strength_ok low on the first, high on the second
		for (n = 0; n < 2; n++) begin
			radio_set.magnitude <= 16'($random(seed));
			radio_set.phase <= 16'($random(seed));
			radio_set.strength_ok <= n[0];
			wr(8'h5A, 8'h30);
			@(posedge aclk);
			chk("upper_local_sel", 1'h1, upper_local_sel);
			for (i = 0; i < 100 && balance_run !== 1'h0; i++) @(posedge aclk);
			rchk(8'h5A, {1'h1, n[0], 2'h2, radio_set.magnitude[11:8]});
			rchk(8'h5B, radio_set.magnitude[7:0]);
			rchk(8'h5D, radio_set.phase[7:0]);
		end
		mode_in <= 3'h0;
		radio_set.cap_low <= 8'($random(seed));
		radio_set.cap_high <= 8'($random(seed));
		wr(8'h4D, 8'h19);
		rchk(8'h4D, 8'h19);
		wr(8'h70, 8'h01);
		@(posedge aclk);
		for (i = 0; i < 100 && cap_cal_run !== 1'h0; i++) @(posedge aclk);
		rchk(8'h52, radio_set.cap_low);
		rchk(8'h53, radio_set.cap_high);
		chk("applied_cap_value", radio_set.cap_low, applied_cap_value);
		rchk(8'h6E, radio_set.cap_low);
		wr(8'h52, 8'h5C);
		repeat (4) @(posedge aclk);
		chk("applied_cap_value", 8'h5C, applied_cap_value);
		rchk(8'h5A, {4'hE, radio_set.magnitude[11:8]});
		$display("test calibration done");
		wr(8'h40, 8'h04);
		for (n = 0; n < 5; n++) begin
			if (n == 4) wr(8'h40, 8'h00);
			{radio_set.tune_above, radio_set.tune_below} <= n[1:0] | {1'h0, n[2]};
			@(posedge aclk);
			mode_in <= 3'h1;
			repeat (4) @(posedge aclk);
			if (n < 4) rchk(8'h40, 8'h04 | n[1:0]);
			chk("lock_loss_irq", n > 0 && n < 4, lock_loss_irq);
			mode_in <= 3'h0;
			{radio_set.tune_above, radio_set.tune_below} <= 2'h0;
			wr(8'h0D, 8'h04);
			rchk(8'h0D, 8'h00);
		end
		$display("test tune range done");
		wr(8'h70, 8'h01);
		@(posedge aclk);
		for (i = 0; i < 100 && cap_cal_run !== 1'h0; i++) @(posedge aclk);
		rchk(8'h52, radio_set.cap_low);
		lost_pulse(1'h1, 1'h1, 1'h1);
		lost_pulse(1'h1, 1'h0, 1'h0);
		lost_pulse(1'h0, 1'h1, 1'h0);
		complete_run;
	end
endmodule
`default_nettype wire
